// file: flash_regs_pkg.sv
// constants shared by the flash command front end and its host bridge
package flash_regs_pkg;
  // -------------------------------------------------------------------
  // device register addresses
  // -------------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD_STATE = 12'hFF8;
  localparam logic [11:0] ADDR_PAGE_GUARD = 12'hFF9;
  localparam logic [11:0] ADDR_KHZ_HIGH = 12'hFFA;
  localparam logic [11:0] ADDR_KHZ_LOW = 12'hFFB;
  localparam logic [7:0] REG_RESET = 8'h00;
  // -------------------------------------------------------------------
  // command codes and status encodings
  // -------------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK_FIRST = 8'h73;
  localparam logic [7:0] CMD_UNLOCK_SECOND = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_GUARD_SELECT = 8'h5E;
  localparam logic [5:0] STAT_LOCKED = 6'h00;
  localparam logic [5:0] STAT_FIRST = 6'h01;
  localparam logic [5:0] STAT_SECOND = 6'h02;
  localparam logic [5:0] STAT_UNLOCKED = 6'h03;
  localparam logic [5:0] STAT_GUARD_SEL = 6'h04;
  localparam logic [5:0] STAT_PROGRAM = 6'h08;
  localparam logic [5:0] STAT_PAGE_ERASE = 6'h10;
  localparam logic [5:0] STAT_MASS_ERASE = 6'h20;
  // -------------------------------------------------------------------
  // field layout of page choice and sectors
  // -------------------------------------------------------------------
  localparam int INFO_EN_BIT = 7;
  localparam int PAGE_W = 7;
  localparam int SECTOR_LSB = 1;
  localparam int SECTOR_W = 3;
  localparam int GUARD_W = 8;
  // -------------------------------------------------------------------
  // operation timing: microseconds measured by the loaded khz value
  // -------------------------------------------------------------------
  localparam logic [16:0] KHZ_PER_MHZ = 17'h003E8;
  localparam logic [19:0] PROG_TIME_US = 20'h00028;
  localparam logic [19:0] PAGE_ERASE_TIME_US = 20'h02710;
  localparam logic [19:0] MASS_ERASE_TIME_US = 20'h04E20;
  // -------------------------------------------------------------------
  // host bridge register offsets and fields
  // -------------------------------------------------------------------
  localparam logic [7:0] HOST_TARGET = 8'h00;
  localparam logic [7:0] HOST_WRITE_GO = 8'h04;
  localparam logic [7:0] HOST_READ_GO = 8'h08;
  localparam logic [7:0] HOST_RESULT = 8'h0C;
  localparam int HOST_DEBUG_BIT = 16;
  localparam int HOST_BUSY_BIT = 8;
endpackage

// file: flash_reg_if.sv
// register access link between the host bridge and the flash front end
`timescale 1ns/10ps
`default_nettype none
interface flash_reg_if;
  logic req;
  logic write;
  logic debug;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport dev (input req, input write, input debug, input addr, input wdata,
               output rdata, output ack);
  modport ctl (output req, output write, output debug, output addr, output wdata,
               input rdata, input ack);
endinterface
`default_nettype wire

// file: flash_op_timer.sv
// microsecond timer paced by the loaded clock frequency in khz
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] khz,
  input wire logic [19:0] dur_us,
  output logic busy_ff,
  output logic done_ff
);
  // -------------------------------------------------------------------
  // pacing: each cycle adds 1000, every khz worth is one microsecond
  // -------------------------------------------------------------------
  logic [16:0] acc_ff;
  logic [19:0] left_ff;
  wire [16:0] khz_eff = (khz == 16'h0000) ? 17'h00001 : {1'b0, khz};
  wire [16:0] acc_sum = acc_ff + flash_regs_pkg::KHZ_PER_MHZ;
  wire us_tick = busy_ff && (acc_sum >= khz_eff);
  wire last_us = (left_ff <= 20'h00001);

  // counts clocks scaled by frequency until the duration expires
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      acc_ff <= 17'h00000;
      left_ff <= 20'h00000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      done_ff <= 1'b0;
      if (start)
      begin
        acc_ff <= 17'h00000;
        left_ff <= dur_us;
        busy_ff <= 1'b1;
      end
      else if (us_tick)
      begin
        acc_ff <= acc_sum - khz_eff;
        left_ff <= left_ff - 20'h00001;
        busy_ff <= !last_us;
        done_ff <= last_us;
      end
      else if (busy_ff)
        acc_ff <= acc_sum;
    end
  end
endmodule // flash_op_timer
`default_nettype wire

// file: flash_unlock_regs.sv
// flash command unlock sequencer with status, page, guard and frequency registers
// Function
// - unlock needs 73H then 8CH consecutively
// - bad value or order relocks at once
// - 95H third command erases active page
// - 63H mass erase only from debugger
// - 5EH after 73H selects guard register
// - command write-only, status read same address
// - status codes locked 0 through select 4
// - upper status bits show running operation
// - status read free, top two bits zero
// - shared address writes page unless guard selected, second unlock step, open to software, or an operation running
// - only next write after 5EH hits guard
// - bit7 info enable, bits 6:0 page
// - info enable maps info area FE00H-FFFFH
// - software keeps upper page bits zero
// - guard bits reset clear, stay set; debugger writes replace them
// - eight guard bits, 1024-byte sector each
// - khz bytes form 16-bit timing value
// - software keeps clock 20KHz to 20MHz
// - page erase only in unguarded sector or from debugger
// - page rewrite must match to activate, except 8CH from debugger opens at once
// - erase completion returns to locked
`timescale 1ns/10ps
`default_nettype none
module flash_unlock_regs #(
  parameter logic [19:0] PROG_US = flash_regs_pkg::PROG_TIME_US,
  parameter logic [19:0] PAGE_ERASE_US = flash_regs_pkg::PAGE_ERASE_TIME_US,
  parameter logic [19:0] MASS_ERASE_US = flash_regs_pkg::MASS_ERASE_TIME_US
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  flash_reg_if.dev bus,
  input wire logic prog_req,
  input wire logic [6:0] prog_page,
  output logic prog_accept_ff,
  output logic [6:0] active_page_ff,
  output logic page_open_ff,
  output logic info_area_en_ff,
  output logic [7:0] sector_guard_bits_ff,
  output logic [15:0] clock_khz_value_ff,
  output logic [5:0] flash_state_ff
);
  // -------------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_LOCKED, S_FIRST, S_SECOND, S_OPEN, S_GUARD, S_PROG, S_PERASE, S_MERASE
  } seq_e;

  seq_e state_ff;
  seq_e nxt_state;
  logic [7:0] page_choice_ff;
  logic [7:0] khz_high_ff;
  logic [7:0] khz_low_ff;
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic timer_done;

  // sector of a page: 1024-byte sectors hold two 512-byte pages
  function automatic logic guarded(input logic [6:0] page, input logic [7:0] guard);
    guarded = guard[page[flash_regs_pkg::SECTOR_LSB +: flash_regs_pkg::SECTOR_W]];
  endfunction

  // status code of a state; busy codes leave the low three bits zero
  function automatic logic [5:0] code_of(input seq_e s);
    case (s)
      S_LOCKED: code_of = flash_regs_pkg::STAT_LOCKED;
      S_FIRST: code_of = flash_regs_pkg::STAT_FIRST;
      S_SECOND: code_of = flash_regs_pkg::STAT_SECOND;
      S_OPEN: code_of = flash_regs_pkg::STAT_UNLOCKED;
      S_GUARD: code_of = flash_regs_pkg::STAT_GUARD_SEL;
      S_PROG: code_of = flash_regs_pkg::STAT_PROGRAM;
      S_PERASE: code_of = flash_regs_pkg::STAT_PAGE_ERASE;
      S_MERASE: code_of = flash_regs_pkg::STAT_MASS_ERASE;
      default: code_of = flash_regs_pkg::STAT_LOCKED;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // access decode
  // -------------------------------------------------------------------
  wire wr = bus.req && bus.write;
  wire rd = bus.req && !bus.write;
  wire busy_state = (state_ff == S_PROG) || (state_ff == S_PERASE) || (state_ff == S_MERASE);
  wire cmd_wr = wr && (bus.addr == flash_regs_pkg::ADDR_CMD_STATE) && !busy_state;
  wire ps_wr = wr && (bus.addr == flash_regs_pkg::ADDR_PAGE_GUARD) && !busy_state;
  wire hi_wr = wr && (bus.addr == flash_regs_pkg::ADDR_KHZ_HIGH);
  wire lo_wr = wr && (bus.addr == flash_regs_pkg::ADDR_KHZ_LOW);
  wire [6:0] new_page = bus.wdata[flash_regs_pkg::PAGE_W-1:0];
  wire page_match = (bus.wdata == page_choice_ff);
  // guard writes go to the guard only right after the select command
  wire guard_wr = ps_wr && (state_ff == S_GUARD);
  // user writes while open are dropped so the opened page cannot move
  wire page_wr = ps_wr && (state_ff != S_GUARD) && (state_ff != S_SECOND)
                 && ((state_ff != S_OPEN) || bus.debug);
  wire erase_ok = bus.debug || !guarded(active_page_ff, sector_guard_bits_ff);
  wire prog_ok = prog_req && (state_ff == S_OPEN)
                 && (bus.debug || ((prog_page == active_page_ff)
                 && !guarded(prog_page, sector_guard_bits_ff)));
  wire start_prog = prog_ok && !cmd_wr && !ps_wr;
  wire start_perase = cmd_wr && (state_ff == S_OPEN)
                      && (bus.wdata == flash_regs_pkg::CMD_PAGE_ERASE) && erase_ok;
  wire start_merase = cmd_wr && (state_ff == S_OPEN) && bus.debug
                      && (bus.wdata == flash_regs_pkg::CMD_MASS_ERASE);
  wire [19:0] dur = start_merase ? MASS_ERASE_US : (start_perase ? PAGE_ERASE_US : PROG_US);
  wire [5:0] nxt_code = code_of(nxt_state);
  wire [7:0] read_mux =
    (bus.addr == flash_regs_pkg::ADDR_CMD_STATE) ? {2'b00, flash_state_ff} :
    (bus.addr == flash_regs_pkg::ADDR_PAGE_GUARD) ? page_choice_ff :
    (bus.addr == flash_regs_pkg::ADDR_KHZ_HIGH) ? khz_high_ff :
    (bus.addr == flash_regs_pkg::ADDR_KHZ_LOW) ? khz_low_ff : flash_regs_pkg::REG_RESET;

  // -------------------------------------------------------------------
  // unlock sequencer
  // -------------------------------------------------------------------
  // any unexpected command or page value falls back to locked
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_LOCKED:
        if (cmd_wr && bus.wdata == flash_regs_pkg::CMD_UNLOCK_FIRST)
          nxt_state = S_FIRST;
      S_FIRST:
        if (cmd_wr)
        begin
          if (bus.wdata == flash_regs_pkg::CMD_UNLOCK_SECOND)
            nxt_state = bus.debug ? S_OPEN : S_SECOND;
          else if (bus.wdata == flash_regs_pkg::CMD_GUARD_SELECT)
            nxt_state = S_GUARD;
          else
            nxt_state = S_LOCKED;
        end
      S_SECOND:
        if (cmd_wr)
          nxt_state = S_LOCKED;
        else if (ps_wr)
          nxt_state = page_match ? S_OPEN : S_LOCKED;
      S_OPEN:
        if (start_perase)
          nxt_state = S_PERASE;
        else if (start_merase)
          nxt_state = S_MERASE;
        else if (cmd_wr)
          nxt_state = S_LOCKED;
        else if (start_prog)
          nxt_state = S_PROG;
      S_GUARD:
        if (cmd_wr || guard_wr)
          nxt_state = S_LOCKED;
      S_PROG:
        if (timer_done)
          nxt_state = S_OPEN;
      S_PERASE, S_MERASE:
        if (timer_done)
          nxt_state = S_LOCKED;
      default:
        nxt_state = S_LOCKED;
    endcase
  end

  // state and visible status move together
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= S_LOCKED;
      flash_state_ff <= flash_regs_pkg::STAT_LOCKED;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      flash_state_ff <= nxt_code;
    end
  end

  // -------------------------------------------------------------------
  // page choice, active page and info area
  // -------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      page_choice_ff <= flash_regs_pkg::REG_RESET;
      active_page_ff <= 7'h00;
      page_open_ff <= 1'b0;
      info_area_en_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (page_wr)
      begin
        page_choice_ff <= bus.wdata;
        info_area_en_ff <= bus.wdata[flash_regs_pkg::INFO_EN_BIT];
      end
      if ((state_ff == S_SECOND && ps_wr && page_match) || (state_ff == S_OPEN && page_wr))
        active_page_ff <= new_page;
      else if (nxt_state == S_OPEN && state_ff == S_FIRST)
        active_page_ff <= page_choice_ff[flash_regs_pkg::PAGE_W-1:0];
      page_open_ff <= (nxt_state == S_OPEN) || (nxt_state == S_PROG) || (nxt_state == S_PERASE);
    end
  end

  // -------------------------------------------------------------------
  // sector guard: set-only for software, debugger may clear
  // -------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sector_guard_bits_ff <= flash_regs_pkg::REG_RESET;
    else if (ce && guard_wr)
      sector_guard_bits_ff <= bus.debug ? bus.wdata : (sector_guard_bits_ff | bus.wdata);
  end

  // -------------------------------------------------------------------
  // frequency value and register read port
  // -------------------------------------------------------------------
  // khz pair is read as one value by the timer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      khz_high_ff <= flash_regs_pkg::REG_RESET;
      khz_low_ff <= flash_regs_pkg::REG_RESET;
      clock_khz_value_ff <= 16'h0000;
      ack_ff <= 1'b0;
      rdata_ff <= flash_regs_pkg::REG_RESET;
      prog_accept_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (hi_wr)
        khz_high_ff <= bus.wdata;
      if (lo_wr)
        khz_low_ff <= bus.wdata;
      clock_khz_value_ff <= {khz_high_ff, khz_low_ff};
      ack_ff <= bus.req;
      if (rd)
        rdata_ff <= read_mux;
      prog_accept_ff <= (state_ff == S_OPEN) && start_prog;
    end
  end

  assign bus.ack = ack_ff;
  assign bus.rdata = rdata_ff;

  // operation duration paced by the loaded frequency
  flash_op_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .start(start_prog || start_perase || start_merase),
    .khz(clock_khz_value_ff),
    .dur_us(dur),
    .busy_ff(),
    .done_ff(timer_done)
  );
endmodule // flash_unlock_regs
`default_nettype wire

// file: flash_host_bridge.sv
// AHB-Lite slave that relays software accesses onto the flash register link
`timescale 1ns/10ps
`default_nettype none
module flash_host_bridge (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout_ff,
  output logic hresp_ff,
  output logic [31:0] hrdata_ff,
  flash_reg_if.ctl link
);
  // -------------------------------------------------------------------
  // bridge state
  // -------------------------------------------------------------------
  logic [11:0] target_ff;
  logic debug_ff;
  logic busy_ff;
  logic req_ff;
  logic write_ff;
  logic [7:0] wdata_ff;
  logic [7:0] result_ff;
  logic wr_pend_ff;
  logic [7:0] wr_off_ff;

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  wire addr_phase = hsel && htrans[1] && hready;
  wire [7:0] off = haddr[7:0];
  wire [31:0] read_mux =
    (off == flash_regs_pkg::HOST_TARGET) ? {15'h0000, debug_ff, 4'h0, target_ff} :
    (off == flash_regs_pkg::HOST_RESULT) ? {23'h000000, busy_ff, result_ff} : 32'h00000000;
  // new link transfers are dropped while one is still outstanding
  wire go_wr = wr_pend_ff && !busy_ff && (wr_off_ff == flash_regs_pkg::HOST_WRITE_GO);
  wire go_rd = wr_pend_ff && !busy_ff && (wr_off_ff == flash_regs_pkg::HOST_READ_GO);
  wire tgt_wr = wr_pend_ff && (wr_off_ff == flash_regs_pkg::HOST_TARGET);

  // zero-wait slave: read data is latched in the address phase
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
      wr_pend_ff <= 1'b0;
      wr_off_ff <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_off_ff <= off;
      if (addr_phase && !hwrite)
        hrdata_ff <= read_mux;
    end
  end

  // -------------------------------------------------------------------
  // link master: one-cycle request, waits for ack
  // -------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      target_ff <= 12'h000;
      debug_ff <= 1'b0;
      busy_ff <= 1'b0;
      req_ff <= 1'b0;
      write_ff <= 1'b0;
      wdata_ff <= 8'h00;
      result_ff <= 8'h00;
    end
    else if (ce)
    begin
      req_ff <= go_wr || go_rd;
      if (tgt_wr)
      begin
        target_ff <= hwdata[11:0];
        debug_ff <= hwdata[flash_regs_pkg::HOST_DEBUG_BIT];
      end
      if (go_wr || go_rd)
      begin
        busy_ff <= 1'b1;
        write_ff <= go_wr;
        wdata_ff <= hwdata[7:0];
      end
      else if (busy_ff && link.ack)
      begin
        busy_ff <= 1'b0;
        if (!write_ff)
          result_ff <= link.rdata;
      end
    end
  end

  assign link.req = req_ff;
  assign link.write = write_ff;
  assign link.debug = debug_ff;
  assign link.addr = target_ff;
  assign link.wdata = wdata_ff;
endmodule // flash_host_bridge
`default_nettype wire

// file: flash_link_properties.sv
// link-level assertions between the host bridge and the flash front end
`timescale 1ns/10ps
`default_nettype none
module flash_link_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req,
  input wire logic write,
  input wire logic debug,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  // -------------------------------------------------------------------
  // decode of link requests
  // -------------------------------------------------------------------
  wire cmd_wr = req && write && (addr == flash_regs_pkg::ADDR_CMD_STATE);
  wire stat_rd = req && !write && (addr == flash_regs_pkg::ADDR_CMD_STATE);
  wire cmd_bad = !(wdata inside {8'h73, 8'h8C, 8'h95, 8'h63, 8'h5E});
  logic [7:0] last_cmd_ff;
  logic last_dbg_ff;
  logic stat_rd_ff;
  logic bad_ff;
  // last command byte kept so a status code can be tied to its cause
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      last_cmd_ff <= 8'h00;
      last_dbg_ff <= 1'b0;
      stat_rd_ff <= 1'b0;
      bad_ff <= 1'b0;
    end
    else
    begin
      stat_rd_ff <= stat_rd;
      if (cmd_wr)
      begin
        last_cmd_ff <= wdata;
        last_dbg_ff <= debug;
      end
      if (req && write)
        bad_ff <= cmd_wr && cmd_bad; // any later write ends the window
    end
  end
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_ack_after_req: assert property (req |-> ##1 ack ##1 !ack)
    else $error("link request not answered by a single ack");
  chk_ack_has_cause: assert property (ack |-> $past(req))
    else $error("link ack without a request");
  chk_status_top_zero: assert property (ack && stat_rd_ff |-> rdata[7:6] == 2'h0)
    else $error("status top bits not zero");
  chk_status_code_legal: assert property (ack && stat_rd_ff |->
    (rdata[5:0] <= 6'h04) || (rdata[5:3] inside {3'h1, 3'h2, 3'h4}))
    else $error("status code outside the defined set");
  chk_first_unlock: assert property (ack && stat_rd_ff && rdata[5:0] == 6'h01 |->
    last_cmd_ff == 8'h73) else $error("first unlock state without first code");
  chk_second_unlock: assert property (ack && stat_rd_ff && rdata[5:0] == 6'h02 |->
    last_cmd_ff == 8'h8C) else $error("second unlock state without second code");
  chk_guard_select: assert property (ack && stat_rd_ff && rdata[5:0] == 6'h04 |->
    last_cmd_ff == 8'h5E) else $error("guard select state without its code");
  chk_page_erase_cause: assert property (ack && stat_rd_ff && rdata[5:3] == 3'h2 |->
    last_cmd_ff == 8'h95) else $error("page erase running without its command");
  chk_mass_erase_debug: assert property (ack && stat_rd_ff && rdata[5:3] == 3'h4 |->
    last_cmd_ff == 8'h63 && last_dbg_ff) else $error("mass erase not from debugger");
  chk_bad_relock: assert property (ack && stat_rd_ff && bad_ff |-> rdata == 8'h00)
    else $error("unknown command did not relock");
endmodule // flash_link_properties
`default_nettype wire

// file: tb_top.sv
// self-checking bench: AHB-Lite master, bridge and flash front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic prog_req = 1'b0;
  logic [6:0] prog_page = 7'h00;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [6:0] active_page;
  logic info_en;
  logic [7:0] guard;
  logic [15:0] khz;
  logic [5:0] state;
  logic prog_accept;
  logic [3:0] seen = 4'h0;
  logic clr = 1'b0;
  logic [31:0] q;
  logic [7:0] junk;
  int n_errors = 0;
  int checks = 0;
  int n;
  always #5 clock = ~clock;
  // -------------------------------------------------------------------
  // design under test: the two ends joined by the link
  // -------------------------------------------------------------------
  flash_reg_if link_if ();
  flash_host_bridge u_flash_host_bridge (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout_ff(hready), .hresp_ff(hresp),
    .hrdata_ff(hrdata), .link(link_if.ctl));
  // short durations keep erase runs to 30 or 40 cycles at the loaded 10000 khz value
  flash_unlock_regs #(.PROG_US(20'h00002), .PAGE_ERASE_US(20'h00003),
    .MASS_ERASE_US(20'h00004)) u_flash_unlock_regs (.clock(clock), .rst_n(rst_n),
    .ce(1'b1), .bus(link_if.dev), .prog_req(prog_req), .prog_page(prog_page),
    .prog_accept_ff(prog_accept), .active_page_ff(active_page), .page_open_ff(),
    .info_area_en_ff(info_en), .sector_guard_bits_ff(guard),
    .clock_khz_value_ff(khz), .flash_state_ff(state));
  flash_link_properties u_flash_link_properties (.clock(clock), .rst_n(rst_n),
    .req(link_if.req), .write(link_if.write), .debug(link_if.debug),
    .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata), .ack(link_if.ack));
  // sticky record of operations; status reads may miss them
  always @(posedge clock)
  begin
    seen <= clr ? 4'h0 : (seen | {prog_accept, state[5:3]});
  end
  // -------------------------------------------------------------------
  // reporting
  // -------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    cmp(32'hDEAD, 32'h0);
    give_verdict();
  endtask
  // -------------------------------------------------------------------
  // bus tasks: one AHB word transfer, then link operations on top
  // -------------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    for (int p = 0; p < 2; p++)
    begin
      k = 0;
      do
      begin
        @(posedge clock);
        k++;
      end
      while (hready !== 1'b1 && k < 40);
      if (hready !== 1'b1)
        timeout();
      if (p == 0)
      begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
    r = hrdata;
  endtask
  // link operation through target, go and result registers
  task automatic dev(input logic wr, input logic [11:0] a, input logic [7:0] d,
    input logic dbg, output logic [7:0] r);
    logic [31:0] s;
    int k;
    ahb(1'b1, flash_regs_pkg::HOST_TARGET, {15'h0, dbg, 4'h0, a}, s);
    ahb(1'b1, wr ? flash_regs_pkg::HOST_WRITE_GO : flash_regs_pkg::HOST_READ_GO,
      {24'h0, d}, s);
    k = 0;
    do
    begin
      ahb(1'b0, flash_regs_pkg::HOST_RESULT, 32'h0, s);
      k++;
    end
    while (s[flash_regs_pkg::HOST_BUSY_BIT] !== 1'b0 && k < 20);
    if (s[flash_regs_pkg::HOST_BUSY_BIT] !== 1'b0)
      timeout();
    r = s[7:0];
  endtask
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    dev(1'b1, a, d, 1'b0, r);
  endtask
  task automatic get(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] r;
    dev(1'b0, a, 8'h00, 1'b0, r);
    cmp({24'h0, r}, {24'h0, exp});
  endtask
  task automatic unlock(input logic [7:0] p);
    put(12'hFF9, p);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h8C);
    put(12'hFF9, p);
  endtask
  // status polled until locked again, bounded
  task automatic poll_lock();
    logic [7:0] r;
    int k;
    k = 0;
    do
    begin
      dev(1'b0, 12'hFF8, 8'h00, 1'b0, r);
      k++;
    end
    while (r !== 8'h00 && k < 60);
    cmp({24'h0, r}, 32'h0);
  endtask
  task automatic clear_seen();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    get(12'hFF8, 8'h00);
    get(12'hFF9, 8'h00);
    cmp({24'h0, guard}, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, q);
    cmp(q | hresp, 32'h0);
    put(12'hFFA, 8'h27);
    put(12'hFFB, 8'h10);
    cmp({16'h0, khz}, 32'h2710);
    get(12'hFFA, 8'h27);
    $display("test reset_and_frequency done");
    put(12'hFF8, 8'h73);
    get(12'hFF8, 8'h01);
    put(12'hFF8, 8'h5E);
    get(12'hFF8, 8'h04);
    put(12'hFF9, 8'h02);
    cmp({24'h0, guard}, 32'h2);
    put(12'hFF9, 8'h05);
    cmp({24'h0, guard}, 32'h2);
    get(12'hFF9, 8'h05);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h5E);
    put(12'hFF9, 8'h00);
    cmp({24'h0, guard}, 32'h2);
    $display("test sector_guard done");
    put(12'hFF9, 8'h02);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h8C);
    get(12'hFF8, 8'h02);
    put(12'hFF9, 8'h02);
    get(12'hFF8, 8'h03);
    cmp({25'h0, active_page}, 32'h2);
    clear_seen();
    put(12'hFF8, 8'h95);
    get(12'hFF8, 8'h00);
    cmp({28'h0, seen}, 32'h0);
    unlock(8'h04);
    clear_seen();
    put(12'hFF8, 8'h95);
    poll_lock();
    cmp({28'h0, seen}, 32'h2);
    $display("test page_erase done");
    put(12'hFF9, 8'h04);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h8C);
    put(12'hFF9, 8'h05);
    get(12'hFF8, 8'h00);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h95);
    get(12'hFF8, 8'h00);
    put(12'hFF8, 8'h73);
    put(12'hFF8, 8'h8C);
    put(12'hFF8, 8'h8C);
    get(12'hFF8, 8'h00);
    $display("test relock done");
    unlock(8'h04);
    clear_seen();
    put(12'hFF8, 8'h63);
    get(12'hFF8, 8'h00);
    cmp({28'h0, seen}, 32'h0);
    dev(1'b1, 12'hFF8, 8'h73, 1'b1, junk);
    dev(1'b1, 12'hFF8, 8'h8C, 1'b1, junk);
    get(12'hFF8, 8'h03);
    clear_seen();
    dev(1'b1, 12'hFF8, 8'h63, 1'b1, junk);
    poll_lock();
    cmp({28'h0, seen}, 32'h4);
    $display("test mass_erase done");
    unlock(8'h04);
    clear_seen();
    prog_page <= 7'h04;
    prog_req <= 1'b1;
    @(posedge clock);
    prog_req <= 1'b0;
    n = 0;
    while (!(seen[0] === 1'b1 && state === flash_regs_pkg::STAT_UNLOCKED) && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) timeout();
    cmp({28'h0, seen}, 32'h9);
    get(12'hFF8, 8'h03);
    put(12'hFF8, 8'h00);
    get(12'hFF8, 8'h00);
    $display("test byte_program done");
    put(12'hFF9, 8'h80);
    cmp({31'h0, info_en}, 32'h1);
    get(12'hFF9, 8'h80);
    put(12'hFF9, 8'h00);
    cmp({31'h0, info_en}, 32'h0);
    $display("test info_area done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
